// *** rtl/ddt_pkg.sv ***
// Constants for the dual tuning and source register bank
// Contract
// - Tuning word is 32-bit signed, four bytes, low byte at lowest address.
// - Oscillator frequency over sample clock equals tuning word over two to 32.
// - Channel B tuning word sits alone at addresses 13 to 16.
// - Phase word is 16-bit unsigned, two bytes, low byte first.
// - Phase offset equals two pi times phase word over two to 16.
// - Selector 0 routes first input, selector 1 routes second input.
// - Selector 2 or 3 routes the test sample register.
// - Address 19 holds A selector bits 1:0 reset 0, B bits 3:2 reset 1.
// - Override clear passes computed exponent unchanged to the converter.
// - Override set forces both channel exponents to 7.
// - Byte-wide registers reached by chip enable, read, write, address, data.
package ddt_pkg;
  localparam logic [7:0] ADDR_CHAN_A_TUNING_WORD = 8'h07;
  localparam logic [7:0] ADDR_PHASE_A = 8'h0B;
  localparam logic [7:0] ADDR_CHAN_B_TUNING_WORD = 8'h0D;
  localparam logic [7:0] ADDR_PHASE_B = 8'h11;
  localparam logic [7:0] ADDR_SOURCE = 8'h13;
  localparam logic [7:0] ADDR_EXP = 8'h14;
  localparam logic [7:0] ADDR_TEST = 8'h30;
  localparam logic [1:0] SRC_A_RST = 2'h0;
  localparam logic [1:0] SRC_B_RST = 2'h1;
  localparam int SRC_A_LSB = 0;
  localparam int SRC_B_LSB = 2;
  localparam logic [1:0] SRC_FIRST = 2'h0;
  localparam logic [1:0] SRC_SECOND = 2'h1;
  localparam logic [2:0] EXP_MAX = 3'h7;
  localparam int EXP_FORCE_BIT = 0;
endpackage : ddt_pkg

// *** rtl/ddt_regs.sv ***
// Tuning, phase, source and exponent registers with two oscillators
`timescale 1ns/1ns
module ddt_regs #(
  parameter int DW = 14,
  parameter int LUTW = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Control bus
  input wire logic i_ce_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  // Sample inputs and computed exponents
  input wire logic [DW-1:0] i_first_sample_input,
  input wire logic [DW-1:0] i_second_sample_input,
  input wire logic [2:0] i_exp_a,
  input wire logic [2:0] i_exp_b,
  // Channel outputs
  output logic [DW-1:0] o_samp_a,
  output logic [DW-1:0] o_samp_b,
  output logic [2:0] o_exp_a,
  output logic [2:0] o_exp_b,
  output logic [15:0] o_nco_phase_a,
  output logic [15:0] o_nco_phase_b,
  output logic [LUTW-1:0] o_sin_a,
  output logic [LUTW-1:0] o_cos_a,
  output logic [LUTW-1:0] o_sin_b,
  output logic [LUTW-1:0] o_cos_b
);
  logic [31:0] freq_reg [2];
  logic [31:0] freq_next [2];
  logic [15:0] phase_reg [2];
  logic [15:0] phase_next [2];
  logic [31:0] acc_reg [2];
  logic [31:0] acc_next [2];
  logic [3:0] src_reg, src_next;
  logic force_reg, force_next;
  logic [DW-1:0] test_reg, test_next;
  logic [7:0] rd_reg, rd_next;
  logic oe_reg, oe_next;
  logic wr_d_reg;
  logic wr_stb;
  logic [DW-1:0] samp_reg [2];
  logic [DW-1:0] samp_next [2];
  logic [2:0] exp_reg [2];
  logic [2:0] exp_next [2];
  logic [15:0] ph_reg [2];
  logic [15:0] ph_next [2];
  logic [LUTW-1:0] sin_reg [2];
  logic [LUTW-1:0] cos_reg [2];

  localparam logic [7:0] ADDR_FREQ_LO = ddt_pkg::ADDR_CHAN_A_TUNING_WORD;
  localparam logic [7:0] ADDR_FREQ_HI = ddt_pkg::ADDR_CHAN_B_TUNING_WORD;
  localparam logic [7:0] ADDR_PH_LO = ddt_pkg::ADDR_PHASE_A;
  localparam logic [7:0] ADDR_PH_HI = ddt_pkg::ADDR_PHASE_B;

  // One write per strobe, taken on the falling edge of the write strobe
  assign wr_stb = !i_ce_n && !i_wr_n && wr_d_reg;

  // Sine of full-circle index from the top eight phase bits, signed, scaled to LUTW bits
  function automatic logic [LUTW-1:0] sine(input logic [15:0] p);
    logic [LUTW-1:0] r;
    real a;
    a = $sin(6.283185307179586 * $itor(p[15:8]) / 256.0);
    r = LUTW'($rtoi(a * $itor((1 << (LUTW - 1)) - 1)));
    return r;
  endfunction : sine

  always_comb begin
    freq_next = freq_reg;
    phase_next = phase_reg;
    src_next = src_reg;
    force_next = force_reg;
    test_next = test_reg;
    if (wr_stb) begin
      for (int c = 0; c < 2; c++) begin
        for (int b = 0; b < 4; b++) begin
          // Low byte at lowest address
          if (i_addr == ((c == 0 ? ADDR_FREQ_LO : ADDR_FREQ_HI) + 8'(b)))
            freq_next[c][8*b +: 8] = i_data;
        end
        for (int b = 0; b < 2; b++) begin
          if (i_addr == ((c == 0 ? ADDR_PH_LO : ADDR_PH_HI) + 8'(b)))
            phase_next[c][8*b +: 8] = i_data;
        end
      end
      if (i_addr == ddt_pkg::ADDR_SOURCE)
        src_next = i_data[3:0];
      if (i_addr == ddt_pkg::ADDR_EXP)
        force_next = i_data[ddt_pkg::EXP_FORCE_BIT];
      // Bus is a byte wide, so the upper test bits stay zero
      if (i_addr == ddt_pkg::ADDR_TEST)
        test_next = DW'(i_data);
    end
  end

  // Read data
  always_comb begin
    rd_next = 8'h00;
    oe_next = !i_ce_n && !i_rd_n;
    for (int c = 0; c < 2; c++) begin
      for (int b = 0; b < 4; b++) begin
        if (i_addr == ((c == 0 ? ADDR_FREQ_LO : ADDR_FREQ_HI) + 8'(b)))
          rd_next = freq_reg[c][8*b +: 8];
      end
      for (int b = 0; b < 2; b++) begin
        if (i_addr == ((c == 0 ? ADDR_PH_LO : ADDR_PH_HI) + 8'(b)))
          rd_next = phase_reg[c][8*b +: 8];
      end
    end
    if (i_addr == ddt_pkg::ADDR_SOURCE)
      rd_next = {4'h0, src_reg};
    if (i_addr == ddt_pkg::ADDR_EXP)
      rd_next = {7'h00, force_reg};
  end

  // Channel datapath
  always_comb begin
    logic [1:0] s;
    s = 2'h0;
    for (int c = 0; c < 2; c++) begin
      s = src_reg[2*c +: 2];
      // Accumulator wraps modulo 2^32
      acc_next[c] = acc_reg[c] + freq_reg[c];
      // Offset of full circle over 2^16
      ph_next[c] = acc_reg[c][31:16] + phase_reg[c];
      if (s == ddt_pkg::SRC_FIRST)
        samp_next[c] = i_first_sample_input;
      else if (s == ddt_pkg::SRC_SECOND)
        samp_next[c] = i_second_sample_input;
      else
        samp_next[c] = test_reg;
      if (force_reg)
        exp_next[c] = ddt_pkg::EXP_MAX;
      else
        exp_next[c] = (c == 0) ? i_exp_a : i_exp_b;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int c = 0; c < 2; c++) begin
        freq_reg[c] <= 32'h0000_0000;
        phase_reg[c] <= 16'h0000;
        acc_reg[c] <= 32'h0000_0000;
        samp_reg[c] <= '0;
        exp_reg[c] <= 3'h0;
        ph_reg[c] <= 16'h0000;
        sin_reg[c] <= '0;
        cos_reg[c] <= '0;
      end
      src_reg <= {ddt_pkg::SRC_B_RST, ddt_pkg::SRC_A_RST};
      force_reg <= 1'b0;
      test_reg <= '0;
      rd_reg <= 8'h00;
      oe_reg <= 1'b0;
      wr_d_reg <= 1'b1;
    end else begin
      freq_reg <= freq_next;
      phase_reg <= phase_next;
      acc_reg <= acc_next;
      samp_reg <= samp_next;
      exp_reg <= exp_next;
      ph_reg <= ph_next;
      for (int c = 0; c < 2; c++) begin
        sin_reg[c] <= sine(ph_reg[c]);
        cos_reg[c] <= sine(ph_reg[c] + 16'h4000);
      end
      src_reg <= src_next;
      force_reg <= force_next;
      test_reg <= test_next;
      rd_reg <= rd_next;
      oe_reg <= oe_next;
      wr_d_reg <= i_ce_n || i_wr_n;
    end
  end

  assign o_data = rd_reg;
  assign o_data_oe = oe_reg;
  assign o_samp_a = samp_reg[0];
  assign o_samp_b = samp_reg[1];
  assign o_exp_a = exp_reg[0];
  assign o_exp_b = exp_reg[1];
  assign o_nco_phase_a = ph_reg[0];
  assign o_nco_phase_b = ph_reg[1];
  assign o_sin_a = sin_reg[0];
  assign o_cos_a = cos_reg[0];
  assign o_sin_b = sin_reg[1];
  assign o_cos_b = cos_reg[1];

  a_force_max: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    force_reg |=> o_exp_a == ddt_pkg::EXP_MAX
      && o_exp_b == ddt_pkg::EXP_MAX)
    else $error("exponent not forced");
  a_exp_pass: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    !force_reg |=> o_exp_a == $past(i_exp_a) && o_exp_b == $past(i_exp_b))
    else $error("exponent altered");
  a_src_first: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    src_reg[1:0] == ddt_pkg::SRC_FIRST
      |=> o_samp_a == $past(i_first_sample_input))
    else $error("channel A source wrong");
  a_src_test: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    src_reg[3] |=> o_samp_b == $past(test_reg))
    else $error("channel B test source wrong");
  a_acc_step: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    ##1 acc_reg[0] == $past(acc_reg[0]) + $past(freq_reg[0]))
    else $error("accumulator step wrong");
  a_freq_byte: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    wr_stb && i_addr == ddt_pkg::ADDR_CHAN_B_TUNING_WORD
      |=> freq_reg[1][7:0] == $past(i_data))
    else $error("tuning byte lost");
  a_phase_hi: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    wr_stb && i_addr == ddt_pkg::ADDR_PHASE_A + 8'h01
      |=> phase_reg[0][15:8] == $past(i_data))
    else $error("phase byte lost");
  a_read_src: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    !i_ce_n && !i_rd_n && i_addr == ddt_pkg::ADDR_SOURCE
      |=> o_data == {4'h0, $past(src_reg)})
    else $error("selector readback wrong");
  c_force: cover property (@(posedge i_clk) force_reg);
  c_test_src: cover property (@(posedge i_clk) src_reg[1]);
  c_freq_wr: cover property (@(posedge i_clk)
    wr_stb && i_addr == ddt_pkg::ADDR_CHAN_A_TUNING_WORD + 8'h03);
endmodule : ddt_regs

// *** tb/ddt_host.sv ***
// Host model for the byte-wide control bus
`timescale 1ns/1ns
module ddt_host (
  // Clock and read-back
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_oe,
  // Bus drive
  output logic o_ce_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [7:0] o_addr,
  output logic [7:0] o_data
);
  initial begin
    {o_ce_n, o_rd_n, o_wr_n} = 3'h7;
    o_addr = 8'h00;
    o_data = 8'h00;
  end
  // One strobe per byte; next call's edge keeps write high a cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    {o_ce_n, o_wr_n, o_addr, o_data} = {2'h0, a, d};
    @(negedge i_clk);
    // Released data must not keep its old value
    {o_ce_n, o_wr_n, o_data} = {2'h3, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [8:0] q);
    @(negedge i_clk);
    {o_ce_n, o_rd_n, o_addr} = {2'h0, a};
    repeat (2) @(negedge i_clk);
    q = {i_oe, i_rdata};
    {o_ce_n, o_rd_n} = 2'h3;
  endtask : rd
endmodule : ddt_host

// *** tb/ddt_regs_tb.sv ***
// Self-checking bench for the tuning and source register bank
`timescale 1ns/1ns
module ddt_regs_tb;
  logic clk, rstn, ce_n, rd_n, wr_n, oe;
  logic [7:0] addr, wdata, rdata;
  logic [13:0] s1 = 14'h0AAA, s2 = 14'h1555, sa, sb;
  logic [2:0] ea = 3'h3, eb = 3'h5, xa, xb;
  logic [15:0] pa, pb, pa0, pb0;
  logic [7:0] sia, coa, sib, cob;
  logic [8:0] q;
  int n_fail = 0, checked = 0;
  // Tuning A = 0x00010000 then phase A, tuning B = 0xFFFF0000 then phase B
  logic [7:0] tv [12] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h34, 8'h12,
    8'h00, 8'h00, 8'hFF, 8'hFF, 8'h78, 8'h56};

  ddt_host H (.i_clk(clk), .i_rdata(rdata), .i_oe(oe), .o_ce_n(ce_n),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(addr), .o_data(wdata));

  ddt_regs DUT (.i_clk(clk), .i_rstn(rstn), .i_ce_n(ce_n), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_addr(addr), .i_data(wdata), .o_data(rdata),
    .o_data_oe(oe), .i_first_sample_input(s1), .i_second_sample_input(s2),
    .i_exp_a(ea), .i_exp_b(eb), .o_samp_a(sa), .o_samp_b(sb),
    .o_exp_a(xa), .o_exp_b(xb), .o_nco_phase_a(pa), .o_nco_phase_b(pb),
    .o_sin_a(sia), .o_cos_a(coa), .o_sin_b(sib), .o_cos_b(cob));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    checked++;
    if (got !== want) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // Bus fills only the low byte of the test register
  function automatic logic [7:0] src(input int s);
    return (s == 0) ? s1[7:0] : (s == 1) ? s2[7:0] : 8'h5A;
  endfunction : src

  initial begin
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 14; i++) begin
      H.rd(8'h07 + 8'(i), q);
      chk(q, (i == 12) ? 9'h104 : 9'h100);
    end
    H.rd(8'h05, q);
    chk(q, 9'h100);
    // Idle oscillators at zero phase: sine zero, cosine full scale
    chk({sia, coa}, 16'h007F);
    chk({sib, cob}, 16'h007F);
    for (int i = 0; i < 12; i++)
      H.wr(8'h07 + 8'(i), tv[i]);
    for (int i = 0; i < 12; i++) begin
      H.rd(8'h07 + 8'(i), q);
      chk(q, {1'b1, tv[i]});
    end
    @(negedge clk);
    pa0 = pa;
    pb0 = pb;
    @(negedge clk);
    chk(pa - pa0, 16'h0001);
    chk(pb - pb0, 16'hFFFF);
    H.wr(8'h30, 8'h5A);
    for (int s = 0; s < 4; s++) begin
      H.wr(8'h13, {4'h0, 2'(3 - s), 2'(s)});
      repeat (3) @(negedge clk);
      chk(sa[7:0], src(s));
      chk(sb[7:0], src(3 - s));
    end
    for (int f = 0; f < 2; f++) begin
      H.wr(8'h14, 8'(f));
      repeat (3) @(negedge clk);
      chk({xa, xb}, (f == 1) ? 6'h3F : {ea, eb});
    end
    give_verdict();
  end

  // Whole run is about 140 cycles
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule : ddt_regs_tb
